// ==== hw/fmd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module fmd_decoder
    import fmd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic INSTR_VALID,
    input wire logic [31:0] INSTR,
    input wire logic COND_PASS,
    input wire logic [31:0] BASE_VALUE,
    input wire logic BUS_ERR_IN,
    input wire logic MEM_ERR_IN,
    input wire logic SEC_ERR_IN,
    input wire logic LD_VALID,
    input wire logic [31:0] LD_WORD1,
    input wire logic [31:0] LD_WORD2,
    output var fmd_dec_t DEC,
    output var fmd_fault_t FAULT,
    output logic WB_EN,
    output logic [31:0] WB_VALUE,
    output logic LD_DVALID,
    output logic [63:0] LD_DATA
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fmd_state_t r;
    fmd_state_t next_r;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    logic [3:0] dest_index_field;
    logic [3:0] first_src_field;
    logic [3:0] second_src_field;
    logic [3:0] base_register_index;
    logic [7:0] register_count_field;
    logic dest_ext;
    logic first_ext;
    logic second_ext;
    logic precision_select_bit;
    logic negate_first_source_bit;
    logic pre_index;
    logic up_bit;
    logic wback_bit;

    assign dest_index_field = INSTR[15:12];
    assign first_src_field = INSTR[19:16];
    assign second_src_field = INSTR[3:0];
    assign base_register_index = INSTR[19:16];
    assign register_count_field = INSTR[7:0];
    assign dest_ext = INSTR[22];
    assign first_ext = INSTR[7];
    assign second_ext = INSTR[5];
    assign precision_select_bit = INSTR[8];
    assign negate_first_source_bit = INSTR[6];
    assign pre_index = INSTR[24];
    assign up_bit = INSTR[23];
    assign wback_bit = INSTR[21];

    // ------------------------------------------------------------
    // Fused multiply decode
    // ------------------------------------------------------------
    logic fused_hit;
    logic fused_neg;
    logic fused_undef;
    fmd_kind_t fused_kind;

    assign fused_hit = (INSTR[31:23] == FUSED_TOP)
        && (INSTR[11:9] == CP_FIELD) && !INSTR[4]
        && ((INSTR[21:20] == FUSED_PLAIN_SEL)
        || (INSTR[21:20] == FUSED_NEG_SEL));
    assign fused_neg = (INSTR[21:20] == FUSED_NEG_SEL);
    // Double fused op refused while the CTRL_SINGLE_ONLY control bit is set
    assign fused_undef = r.ctrl[CTRL_SINGLE_ONLY]
        && precision_select_bit;

    always_comb begin
        if (fused_neg) begin
            fused_kind = negate_first_source_bit
                ? KIND_FUSED_NEG_MUL_ADD : KIND_FUSED_NEG_MUL_SUB;
        end else begin
            fused_kind = negate_first_source_bit
                ? KIND_FUSED_MUL_SUB : KIND_FUSED_MUL_ADD;
        end
    end

    // ------------------------------------------------------------
    // Load multiple decode
    // ------------------------------------------------------------
    logic ldm_hit;
    logic ldm_dbl;
    logic ldm_related;
    logic ldm_single_ld;
    logic ldm_undef;
    logic ldm_unpred;
    logic ldm_exec;
    logic [7:0] ldm_regs;
    logic [4:0] ldm_first;
    logic [8:0] ldm_end;
    logic [31:0] ldm_offset;
    logic [31:0] ldm_new_base;
    logic stack_violation;

    assign ldm_hit = (INSTR[31:25] == LDM_TOP) && INSTR[20]
        && (INSTR[11:9] == CP_FIELD);
    assign ldm_dbl = INSTR[8];
    assign ldm_related = ldm_dbl
        ? (!pre_index && !up_bit && !wback_bit)
        : (!pre_index && !up_bit);
    assign ldm_single_ld = pre_index && !wback_bit;
    assign ldm_undef = ldm_dbl
        ? ((pre_index == up_bit) && wback_bit)
        : (pre_index && up_bit && wback_bit);
    // Left over: 010, 011 and 101 only
    assign ldm_exec = ldm_hit && !ldm_related && !ldm_single_ld
        && !ldm_undef;
    assign ldm_regs = ldm_dbl
        ? {1'b0, register_count_field[7:1]}
        : register_count_field;
    assign ldm_first = fmd_reg_index(ldm_dbl, dest_index_field,
        dest_ext);
    assign ldm_end = {4'h0, ldm_first} + {1'b0, ldm_regs};
    assign ldm_offset = {22'h0, register_count_field, 2'b00};
    assign ldm_new_base = up_bit
        ? BASE_VALUE + ldm_offset
        : BASE_VALUE - ldm_offset;

    always_comb begin
        ldm_unpred = 1'b0;
        if (base_register_index == PC_INDEX) begin
            ldm_unpred = 1'b1;
        end else if (ldm_regs == 8'h00) begin
            ldm_unpred = 1'b1;
        end else if (ldm_end > BANK_REGS) begin
            ldm_unpred = 1'b1;
        end else if (ldm_dbl && ({1'b0, ldm_regs} > MAX_DREGS)) begin
            ldm_unpred = 1'b1;
        end else if (ldm_dbl && r.ctrl[CTRL_SMALL_BANK]
                && (ldm_end > SMALL_BANK_REGS)) begin
            ldm_unpred = 1'b1;
        end
    end

    // New stack pointer below limit faults
    assign stack_violation = ldm_exec && !ldm_unpred && wback_bit
        && (base_register_index == SP_INDEX)
        && (ldm_new_base < r.sp_limit);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic apb_access;
    logic ext_fault;
    logic any_undef;
    logic any_unpred;
    logic executes;

    assign apb_access = PSEL && PENABLE;
    assign ext_fault = BUS_ERR_IN || MEM_ERR_IN || SEC_ERR_IN;
    assign any_undef = (fused_hit && fused_undef)
        || (ldm_hit && !ldm_related && !ldm_single_ld && ldm_undef);
    assign any_unpred = ldm_exec && ldm_unpred;
    assign executes = INSTR_VALID && COND_PASS;

    always_comb begin
        next_r = r;

        // Bus slave: answer one cycle into access phase
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (apb_access && !r.pready) begin
            next_r.pready = 1'b1;
            if (PADDR == REG_CTRL) begin
                next_r.prdata = {29'h0, r.ctrl};
            end else if (PADDR == REG_STATUS) begin
                next_r.prdata = {25'h0, r.fault.valid, r.dec.unpred,
                    r.dec.undef, r.dec.dbl, r.dec.kind};
            end else if (PADDR == REG_SP_LIMIT) begin
                next_r.prdata = r.sp_limit;
            end else if (PADDR == REG_COUNT) begin
                next_r.prdata = {r.unpred_cnt, r.undef_cnt};
            end else begin
                next_r.prdata = 32'h0;
                next_r.pslverr = 1'b1;
            end
        end
        if (apb_access && r.pready && PWRITE && !r.pslverr) begin
            if (PADDR == REG_CTRL) begin
                next_r.ctrl = PWDATA[2:0];
            end else if (PADDR == REG_SP_LIMIT) begin
                next_r.sp_limit = PWDATA;
            end
        end

        // Decode result, one cycle after the instruction
        next_r.dec = '0;
        next_r.dec.valid = INSTR_VALID;
        next_r.dec.kind = KIND_NONE;
        if (fused_hit) begin
            next_r.dec.kind = fused_kind;
            next_r.dec.dbl = precision_select_bit;
            next_r.dec.neg_src1 = negate_first_source_bit;
            next_r.dec.neg_addend = fused_neg;
            next_r.dec.single_round = 1'b1;
            next_r.dec.dst = fmd_reg_index(precision_select_bit,
                dest_index_field, dest_ext);
            next_r.dec.src1 = fmd_reg_index(precision_select_bit,
                first_src_field, first_ext);
            next_r.dec.src2 = fmd_reg_index(precision_select_bit,
                second_src_field, second_ext);
            next_r.dec.undef = fused_undef;
            next_r.dec.wr_en = executes && !fused_undef
                && !ext_fault;
        end else if (ldm_hit) begin
            next_r.dec.dbl = ldm_dbl;
            next_r.dec.base = base_register_index;
            next_r.dec.add = up_bit;
            next_r.dec.wback = wback_bit;
            next_r.dec.dst = ldm_first;
            next_r.dec.count = ldm_regs;
            next_r.dec.offset = ldm_offset;
            if (ldm_related) begin
                next_r.dec.kind = KIND_RELATED;
            end else if (ldm_single_ld) begin
                next_r.dec.kind = KIND_LOAD_SINGLE;
            end else begin
                next_r.dec.kind = KIND_LOAD_MULTIPLE;
                next_r.dec.undef = ldm_undef;
                next_r.dec.unpred = ldm_exec && ldm_unpred;
                next_r.dec.wr_en = executes && ldm_exec && !ldm_unpred
                    && !ext_fault && !stack_violation;
            end
        end

        // Base writeback
        next_r.wb_en = executes && ldm_exec && !ldm_unpred
            && wback_bit && !ext_fault
            && !stack_violation;
        next_r.wb_value = ldm_new_base;

        // Fault routing to exception logic
        next_r.fault = '0;
        if (executes && (ext_fault || any_undef
                || stack_violation)) begin
            next_r.fault.valid = 1'b1;
            next_r.fault.bus_error_fault = BUS_ERR_IN;
            next_r.fault.memory_protection_fault = MEM_ERR_IN;
            next_r.fault.security_violation_fault = SEC_ERR_IN;
            next_r.fault.bad_use_fault = any_undef
                || stack_violation;
        end

        // Event counters
        if (INSTR_VALID && any_undef) begin
            next_r.undef_cnt = r.undef_cnt + 16'h1;
        end
        if (INSTR_VALID && any_unpred) begin
            next_r.unpred_cnt = r.unpred_cnt + 16'h1;
        end

        // Double word assembly by endianness
        next_r.ld_dvalid = LD_VALID;
        if (LD_VALID) begin
            next_r.ld_data = r.ctrl[CTRL_BIG_ENDIAN]
                ? {LD_WORD1, LD_WORD2}
                : {LD_WORD2, LD_WORD1};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            r <= '0;
            r.ctrl <= CTRL_RESET;
            r.sp_limit <= SP_LIMIT_RESET;
            r.undef_cnt <= COUNT_RESET;
            r.unpred_cnt <= COUNT_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign DEC = r.dec;
    assign FAULT = r.fault;
    assign WB_EN = r.wb_en;
    assign WB_VALUE = r.wb_value;
    assign LD_DVALID = r.ld_dvalid;
    assign LD_DATA = r.ld_data;

endmodule // fmd_decoder

`default_nettype wire

// ==== hw/fmd_pkg.sv ====
package fmd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_SP_LIMIT = 12'h008;
    localparam logic [11:0] REG_COUNT = 12'h00C;

    localparam int CTRL_SINGLE_ONLY = 0;
    localparam int CTRL_SMALL_BANK = 1;
    localparam int CTRL_BIG_ENDIAN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [31:0] SP_LIMIT_RESET = 32'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0;

    // ------------------------------------------------------------
    // Encoding constants
    // ------------------------------------------------------------
    localparam logic [8:0] FUSED_TOP = 9'h1DD;
    localparam logic [6:0] LDM_TOP = 7'h76;
    localparam logic [2:0] CP_FIELD = 3'h5;
    localparam logic [1:0] FUSED_PLAIN_SEL = 2'h2;
    localparam logic [1:0] FUSED_NEG_SEL = 2'h1;
    localparam logic [3:0] PC_INDEX = 4'hF;
    localparam logic [3:0] SP_INDEX = 4'hD;
    localparam logic [8:0] MAX_DREGS = 9'h010;
    localparam logic [8:0] BANK_REGS = 9'h020;
    localparam logic [8:0] SMALL_BANK_REGS = 9'h010;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_FUSED_MUL_ADD,
        KIND_FUSED_MUL_SUB,
        KIND_FUSED_NEG_MUL_ADD,
        KIND_FUSED_NEG_MUL_SUB,
        KIND_LOAD_MULTIPLE,
        KIND_LOAD_SINGLE,
        KIND_RELATED
    } fmd_kind_t;

    typedef struct packed {
        logic valid;
        fmd_kind_t kind;
        logic dbl;
        logic neg_src1;
        logic neg_addend;
        logic single_round;
        logic wr_en;
        logic undef;
        logic unpred;
        logic [4:0] dst;
        logic [4:0] src1;
        logic [4:0] src2;
        logic [3:0] base;
        logic add;
        logic wback;
        logic [7:0] count;
        logic [31:0] offset;
    } fmd_dec_t;

    typedef struct packed {
        logic valid;
        logic bus_error_fault;
        logic bad_use_fault;
        logic memory_protection_fault;
        logic security_violation_fault;
    } fmd_fault_t;

    typedef struct packed {
        fmd_dec_t dec;
        fmd_fault_t fault;
        logic wb_en;
        logic [31:0] wb_value;
        logic ld_dvalid;
        logic [63:0] ld_data;
        logic [2:0] ctrl;
        logic [31:0] sp_limit;
        logic [15:0] undef_cnt;
        logic [15:0] unpred_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fmd_state_t;

    // Register index assembly for single or double precision
    function automatic logic [4:0] fmd_reg_index(
        input logic dbl,
        input logic [3:0] field,
        input logic ext
    );
        return dbl ? {ext, field} : {field, ext};
    endfunction

endpackage

// ==== sim/fmd_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fmd_decoder_tb
    import fmd_pkg::*;
;
    logic SYS_CLK = 1'h0;
    logic RESET = 1'h1;
    logic PSEL = 1'h0;
    logic PENABLE = 1'h0;
    logic PWRITE = 1'h0;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic INSTR_VALID = 1'h0;
    logic [31:0] INSTR = 32'h0;
    logic COND_PASS = 1'h0;
    logic [31:0] BASE_VALUE = 32'h0;
    logic [2:0] ERRS = 3'h0;
    logic LD_VALID;
    logic [31:0] LD_WORD1;
    logic [31:0] LD_WORD2;
    fmd_dec_t DEC;
    fmd_fault_t FAULT;
    logic WB_EN;
    logic [31:0] WB_VALUE;
    logic LD_DVALID;
    logic [63:0] LD_DATA;
    logic ld_req = 1'h0;
    logic [3:0] ld_lat = 4'h0;
    logic [2:0] ctrl = 3'h0;
    logic [31:0] splim = 32'h0;
    logic [31:0] w1q;
    logic [31:0] w2q;
    logic [31:0] q;
    logic [31:0] i;
    logic e;
    int failures = 0;
    int checks = 0;
    initial forever #2 SYS_CLK = ~SYS_CLK;
    fmd_decoder fmd_decoder_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
        .COND_PASS(COND_PASS), .BASE_VALUE(BASE_VALUE),
        .BUS_ERR_IN(ERRS[0]), .MEM_ERR_IN(ERRS[1]), .SEC_ERR_IN(ERRS[2]),
        .LD_VALID(LD_VALID), .LD_WORD1(LD_WORD1), .LD_WORD2(LD_WORD2),
        .DEC(DEC), .FAULT(FAULT), .WB_EN(WB_EN), .WB_VALUE(WB_VALUE),
        .LD_DVALID(LD_DVALID), .LD_DATA(LD_DATA));
    fmd_mem_model fmd_mem_model_inst (.clk(SYS_CLK), .req(ld_req),
        .lat(ld_lat), .ld_valid(LD_VALID), .w1(LD_WORD1), .w2(LD_WORD2));
    always @(posedge SYS_CLK) begin
        if (LD_VALID) begin
            w1q <= LD_WORD1;
            w2q <= LD_WORD2;
        end
    end
    // ----
    // Helpers
    // ----
    task automatic chk(input string nm, input logic [63:0] s,
        input logic [63:0] x);
        checks++;
        if (s !== x) begin
            failures++;
            $display("FAIL %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do @(posedge SYS_CLK); while (!PREADY);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask
    task automatic setctrl(input logic [2:0] v);
        ctrl = v;
        apb(1'h1, REG_CTRL, {29'h0, v});
    endtask
    function automatic logic [63:0] fz(input fmd_dec_t d);
        return 64'({d.dbl, d.neg_src1, d.neg_addend, d.single_round,
            d.dst, d.src1, d.src2});
    endfunction
    function automatic logic [63:0] lz(input fmd_dec_t d);
        return 64'({d.dst, d.count, d.offset, d.add, d.wback});
    endfunction
    function automatic fmd_dec_t exp_dec(input logic [31:0] i);
        fmd_dec_t x;
        logic [8:0] en;
        x = '0;
        x.dbl = i[8];
        x.dst = i[8] ? {i[22], i[15:12]} : {i[15:12], i[22]};
        if (i[31:25] == LDM_TOP) begin
            x.count = i[8] ? {1'h0, i[7:1]} : i[7:0];
            x.offset = {22'h0, i[7:0], 2'h0};
            x.add = i[23];
            x.wback = i[21];
            x.undef = i[21] && (i[8] ? i[24] == i[23] : i[24] && i[23]);
            en = 9'(x.dst) + 9'(x.count);
            x.unpred = !x.undef && (i[19:16] == PC_INDEX
                || x.count == 8'h0 || en > BANK_REGS || i[8]
                && (9'(x.count) > MAX_DREGS
                || ctrl[CTRL_SMALL_BANK] && en > SMALL_BANK_REGS));
            if (!i[24] && !i[23] && (!i[21] || !i[8])) x.kind = KIND_RELATED;
            else if (i[24] && !i[21]) x.kind = KIND_LOAD_SINGLE;
            else x.kind = KIND_LOAD_MULTIPLE;
        end else begin
            x.neg_src1 = i[6];
            x.neg_addend = i[21:20] == FUSED_NEG_SEL;
            x.single_round = 1'h1;
            x.undef = i[8] && ctrl[CTRL_SINGLE_ONLY];
            x.src1 = i[8] ? {i[7], i[19:16]} : {i[19:16], i[7]};
            x.src2 = i[8] ? {i[5], i[3:0]} : {i[3:0], i[5]};
            if (x.neg_addend) x.kind = i[6] ? KIND_FUSED_NEG_MUL_ADD
                : KIND_FUSED_NEG_MUL_SUB;
            else x.kind = i[6] ? KIND_FUSED_MUL_SUB : KIND_FUSED_MUL_ADD;
        end
        return x;
    endfunction
    task automatic run(input logic [31:0] i, input logic c,
        input logic [31:0] b, input logic [2:0] er);
        fmd_dec_t x;
        logic [31:0] nb;
        logic ok;
        logic stk;
        fmd_fault_t fx;
        x = exp_dec(i);
        nb = x.add ? b + x.offset : b - x.offset;
        ok = x.kind == KIND_LOAD_MULTIPLE && !x.undef && !x.unpred;
        stk = ok && x.wback && i[19:16] == SP_INDEX && nb < splim;
        fx = {1'h0, c && er[0], c && (x.undef || stk), c && er[1],
            c && er[2]};
        fx.valid = |fx;
        @(posedge SYS_CLK);
        INSTR_VALID <= 1'h1;
        INSTR <= i;
        COND_PASS <= c;
        BASE_VALUE <= b;
        ERRS <= er;
        @(posedge SYS_CLK);
        INSTR_VALID <= 1'h0;
        ERRS <= 3'h0;
        @(negedge SYS_CLK);
        chk("valid", 64'(DEC.valid), 64'h1);
        chk("wr_en", 64'(DEC.wr_en), 64'(x.kind < KIND_LOAD_MULTIPLE
            ? c && !x.undef && !er : ok && c && !er && !stk));
        chk("undef", 64'(DEC.undef), 64'(x.undef));
        if (!x.undef) chk("kind", 64'(DEC.kind), 64'(x.kind));
        if (!x.undef && x.kind < KIND_LOAD_MULTIPLE)
            chk("fused", fz(DEC), fz(x));
        if (ok || x.unpred) chk("ldm", lz(DEC), lz(x));
        if (x.kind == KIND_LOAD_MULTIPLE && !x.undef)
            chk("unpred", 64'(DEC.unpred), 64'(x.unpred));
        chk("wb_en", 64'(WB_EN), 64'(ok && x.wback && c && !er && !stk));
        chk("fault", 64'(FAULT), 64'(fx));
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(43));
        repeat (20) @(posedge SYS_CLK);
        RESET <= 1'h0;
        apb(1'h0, REG_CTRL, 32'h0);
        chk("ctrl", 64'(q), 64'(CTRL_RESET));
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped", 64'({e, q}), 64'h1_0000_0000);
        for (int k = 0; k < 800; k++) begin
            if (k % 200 == 0) setctrl(3'(k / 200));
            i = $urandom;
            if (k[0]) begin
                i[31:23] = FUSED_TOP;
                i[21:20] = i[20] ? FUSED_NEG_SEL : FUSED_PLAIN_SEL;
                i[4] = 1'h0;
            end else begin
                i[31:25] = LDM_TOP;
                i[20] = 1'h1;
                i[7:0] = 8'($urandom_range(0, 40));
                if (k % 10 == 0) i[19:16] = PC_INDEX;
            end
            i[11:9] = CP_FIELD;
            run(i, $urandom_range(0, 7) != 0, $urandom, 3'h0);
        end
        setctrl(3'h0);
        foreach (q[j]) run(32'hECD20B1E + {j[3:0], 12'h0} + 32'(j[1]), 1'h1,
            32'h100, 3'h0);
        splim = 32'h1000;
        apb(1'h1, REG_SP_LIMIT, splim);
        apb(1'h0, REG_SP_LIMIT, 32'h0);
        chk("sp_limit", 64'(q), 64'(splim));
        run(32'hECBD0B04, 1'h1, 32'h100, 3'h0);
        run(32'hECBD0B04, 1'h1, 32'h2000, 3'h0);
        for (int j = 0; j < 3; j++) run(32'hECB30B04, 1'h1, 32'h40, 3'(1 << j));
        run(32'hECB30B04, 1'h0, 32'h40, 3'h1);
        for (int j = 0; j < 4; j++) begin
            setctrl({j[1], 2'h0});
            ld_lat <= 4'(j * 3);
            ld_req <= 1'h1;
            @(posedge SYS_CLK);
            ld_req <= 1'h0;
            repeat (40) if (!LD_DVALID) @(negedge SYS_CLK);
            chk("ld", LD_DATA, j[1] ? {w1q, w2q} : {w2q, w1q});
        end
        final_report();
    end
endmodule // fmd_decoder_tb
`default_nettype wire

// ==== sim/fmd_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fmd_mem_model (
    input wire logic clk,
    input wire logic req,
    input wire logic [3:0] lat,
    output logic ld_valid,
    output logic [31:0] w1,
    output logic [31:0] w2
);
    logic busy = 1'h0;
    logic [3:0] cnt = 4'h0;
    logic [15:0] seq = 16'h0;
    initial begin
        ld_valid = 1'h0;
        w1 = 32'h0;
        w2 = 32'h0;
    end
    // Idle words toggle so stale data never looks valid
    always @(posedge clk) begin
        ld_valid <= 1'h0;
        w1 <= ~w1;
        w2 <= ~w2;
        if (req) begin
            busy <= 1'h1;
            cnt <= lat;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'h0;
            ld_valid <= 1'h1;
            seq <= seq + 16'h1;
            w1 <= {16'hA5C3, seq};
            w2 <= {16'h3C5A, seq};
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule // fmd_mem_model
`default_nettype wire

// ==== sim/fmd_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module fmd_props
    import fmd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic INSTR_VALID,
    input wire logic [31:0] INSTR,
    input wire logic COND_PASS,
    input wire logic [31:0] BASE_VALUE,
    input wire logic LD_VALID,
    input wire fmd_dec_t DEC,
    input wire fmd_fault_t FAULT,
    input wire logic WB_EN,
    input wire logic [31:0] WB_VALUE,
    input wire logic LD_DVALID
);
    logic [31:0] iq;
    logic [31:0] bq;
    logic [31:0] off;
    always_ff @(posedge SYS_CLK) begin
        iq <= INSTR;
        bq <= BASE_VALUE;
    end
    assign off = {22'h0, iq[7:0], 2'h0};
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    // ----
    // Sequences
    // ----
    sequence s_fused;
        INSTR_VALID && INSTR[31:23] == FUSED_TOP && INSTR[11:9] == CP_FIELD
            && !INSTR[4] && (INSTR[21:20] == FUSED_PLAIN_SEL
            || INSTR[21:20] == FUSED_NEG_SEL);
    endsequence
    sequence s_ldm_ok;
        INSTR_VALID && INSTR[31:25] == LDM_TOP && INSTR[20]
            && INSTR[11:9] == CP_FIELD && (!INSTR[24] && INSTR[23]
            || INSTR[24] && !INSTR[23] && INSTR[21]);
    endsequence
    // ----
    // Checks
    // ----
    chk_valid_lat: assert property (INSTR_VALID |=> DEC.valid)
        else $error("decode result missing");
    chk_prec_bit: assert property (s_fused |=> DEC.dbl == iq[8])
        else $error("precision bit wrong");
    chk_dst_index: assert property (s_fused |=> DEC.undef
        || DEC.dst == (iq[8] ? {iq[22], iq[15:12]} : {iq[15:12], iq[22]}))
        else $error("destination index wrong");
    chk_src1_index: assert property (s_fused |=> DEC.undef
        || DEC.src1 == (iq[8] ? {iq[7], iq[19:16]} : {iq[19:16], iq[7]}))
        else $error("first source index wrong");
    chk_src2_index: assert property (s_fused |=> DEC.undef
        || DEC.src2 == (iq[8] ? {iq[5], iq[3:0]} : {iq[3:0], iq[5]}))
        else $error("second source index wrong");
    chk_neg_first: assert property (s_fused |=> DEC.neg_src1 == iq[6])
        else $error("first source negate wrong");
    chk_neg_addend: assert property (s_fused |=>
        DEC.neg_addend == (iq[21:20] == FUSED_NEG_SEL))
        else $error("addend negate wrong");
    chk_ldm_offset: assert property (s_ldm_ok |=>
        DEC.offset == off)
        else $error("load offset wrong");
    chk_base_pc: assert property (s_ldm_ok ##0 (INSTR[19:16] == PC_INDEX)
        |=> DEC.unpred && !WB_EN)
        else $error("base fifteen not flagged");
    chk_wb_value: assert property (WB_EN |-> iq[21]
        && WB_VALUE == (iq[23] ? bq + off : bq - off))
        else $error("writeback value wrong");
    chk_fault_nowb: assert property (FAULT.valid |-> !WB_EN)
        else $error("writeback despite fault");
    chk_cond_fail: assert property (INSTR_VALID && !COND_PASS
        |=> !WB_EN && !FAULT.valid)
        else $error("failed condition had effect");
    chk_ld_pulse: assert property (LD_VALID |=> LD_DVALID)
        else $error("combined double missing");
endmodule // fmd_props
bind fmd_decoder fmd_props fmd_props_inst (
    .SYS_CLK,
    .RESET,
    .INSTR_VALID,
    .INSTR,
    .COND_PASS,
    .BASE_VALUE,
    .LD_VALID,
    .DEC,
    .FAULT,
    .WB_EN,
    .WB_VALUE,
    .LD_DVALID
);
`default_nettype wire
